/* File: verilog/scr_pkg.sv */
// constants for the stepper serial command register bank
// assumes a 50 MHz system clock that oversamples the serial link pins
// Behaviour
// - chip select low frames a word; msb-first on rising clock; last 20 bits latch
// - beyond 20 clocks, input bits reappear on serial output 20 clocks later
// - a transaction writes one of five write-only registers unless bits 19:18 are 01; none read back
// - bits 19:18(:17) pick driver control, chopper, adaptive, load sense, driver config
// - driver control layout follows the held step-direction-disable bit
// - disable set: ignore step/direction, coil currents come from driver control
// - disable clear: step inputs used; interpolation bit 9, double edge 8, resolution 3:0
// - direct mode: coil a polarity is bit 17, one reverses the current
// - direct mode: coil b polarity is bit 8, one reverses the current
// - coil a magnitude bits 16:9, coil b 7:0; host keeps each at most 248
// - chopper fields: blank, mode, random off, decrement, end, start, off time
// - adaptive fields: minimum select, decrement speed, upper, increment, lower threshold
// - load sense fields: filter bit 16, signed threshold 14:8, current scale 4:0
// - driver config: test, slopes, short detect, disable bit 7, sense, response select
// - bits 3, 2 and 0 of driver config ignored on the base variant
// - response select picks position, load measurement, or load upper bits plus scale
// - response bits 7:0: standstill, open loads, ground shorts, overtemp, stall
package scr_pkg;
	localparam int scr_word_bits = 20;
	localparam logic [scr_word_bits-1:0] scr_reg_reset = 20'h00000;
	// target decode on bits 19:18 for driver control, bits 19:17 for the rest
	localparam logic [1:0] scr_sel_drvctl = 2'h0;
	localparam logic [2:0] scr_sel_chop = 3'h4;
	localparam logic [2:0] scr_sel_adapt = 3'h5;
	localparam logic [2:0] scr_sel_sense = 3'h6;
	localparam logic [2:0] scr_sel_drvcfg = 3'h7;
	// driver config field positions
	localparam int scr_pos_step_direction_disable = 7;
	localparam int scr_pos_response_select = 4;
	localparam int scr_pos_overtemp_sensitivity = 3;
	localparam int scr_pos_short_sensitivity = 2;
	localparam int scr_pos_s2vs = 0;
	// driver control fields
	localparam int scr_pos_pha = 17;
	localparam int scr_pos_ca = 9;
	localparam int scr_pos_phb = 8;
	localparam int scr_pos_cb = 0;
	localparam int scr_pos_step_interpolation = 9;
	localparam int scr_pos_double_edge_step = 8;
	localparam int scr_pos_microstep_resolution = 0;
	// response select encodings
	localparam logic [1:0] scr_rd_position = 2'h0;
	localparam logic [1:0] scr_rd_load = 2'h1;
	localparam logic [1:0] scr_rd_load_scale = 2'h2;
	typedef enum logic [2:0] {
		scr_idle_s = 3'b001,
		scr_shift_s = 3'b010,
		scr_latch_s = 3'b100
	} scr_state_t;
endpackage

/* File: verilog/scr_top.sv */
// serial command decoder with five write-only registers and a response word
// assumes link pins are asynchronous; link clock well below clock / 4
module scr_top (
	// system
	input wire logic clock,
	input wire logic arst_n,
	// serial link pins
	input wire logic link_sck,
	input wire logic link_cs_n,
	input wire logic link_sdi,
	output logic link_sdo,
	// variant: high for the enhanced part
	input wire logic enhanced_variant,
	// status for the response word
	input wire logic [9:0] microstep_position,
	input wire logic [9:0] load_measurement,
	input wire logic [4:0] actual_current_scale,
	input wire logic standstill,
	input wire logic open_load_b,
	input wire logic open_load_a,
	input wire logic ground_short_b,
	input wire logic ground_short_a,
	input wire logic overtemp_prewarning,
	input wire logic overtemp_shutdown,
	input wire logic stall_flag,
	// raw registers
	output logic [19:0] driver_control,
	output logic [19:0] chopper_config,
	output logic [19:0] adaptive_current_config,
	output logic [19:0] load_sense_config,
	output logic [19:0] driver_config,
	// decoded driver control
	output logic step_direction_disable,
	output logic coil_a_polarity,
	output logic [7:0] coil_a_magnitude,
	output logic coil_b_polarity,
	output logic [7:0] coil_b_magnitude,
	output logic step_interpolation,
	output logic double_edge_step,
	output logic [3:0] microstep_resolution,
	// chopper
	output logic [1:0] blank_time,
	output logic chopper_mode_select,
	output logic random_off_time,
	output logic [1:0] hysteresis_decrement,
	output logic [3:0] hysteresis_end,
	output logic [2:0] hysteresis_start,
	output logic [3:0] off_time,
	// adaptive current
	output logic minimum_current_select,
	output logic [1:0] decrement_speed,
	output logic [3:0] upper_threshold,
	output logic [1:0] increment_step,
	output logic [3:0] lower_threshold,
	// load sense
	output logic measurement_filter,
	output logic [6:0] load_threshold,
	output logic [4:0] current_scale,
	// driver config
	output logic test_mode,
	output logic [1:0] high_side_slope,
	output logic [1:0] low_side_slope,
	output logic short_detect_disable,
	output logic [1:0] short_detect_timer,
	output logic sense_voltage,
	output logic [1:0] response_select,
	output logic overtemp_sensitivity,
	output logic short_sensitivity,
	output logic supply_short_enable,
	// one-cycle pulse per accepted command
	output logic command_strobe
);
	import scr_pkg::*;

	logic [2:0] sck_sync;
	logic [2:0] cs_sync;
	logic [1:0] sdi_sync;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic [19:0] shift_in;
	logic [19:0] shift_out;
	logic [19:0] next_response;
	logic [19:0] cmd;
	logic [19:0] latched;
	logic rise_seen;
	logic frame_active;
	logic wr_driver_control;
	logic wr_chopper_config;
	logic wr_adaptive_current_config;
	logic wr_load_sense_config;
	logic wr_driver_config;
	scr_state_t state;
	scr_state_t next_state;

	// two stages before use; third stage only keeps the prior level
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sck_sync <= 3'h7;
		end else begin
			sck_sync <= {sck_sync[1:0], link_sck};
		end
	end

	// reset level matches the idle pin, so no false edge after reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cs_sync <= 3'h7;
		end else begin
			cs_sync <= {cs_sync[1:0], link_cs_n};
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sdi_sync <= 2'h0;
		end else begin
			sdi_sync <= {sdi_sync[0], link_sdi};
		end
	end

	assign sck_rise = sck_sync[1] & ~sck_sync[2];
	assign sck_fall = ~sck_sync[1] & sck_sync[2];
	assign cs_fall = ~cs_sync[1] & cs_sync[2];
	assign cs_rise = cs_sync[1] & ~cs_sync[2];
	assign frame_active = ~cs_sync[1];

	always_comb begin
		next_state = state;
		case (state)
			scr_idle_s: begin
				if (cs_fall) begin
					next_state = scr_shift_s;
				end
			end
			scr_shift_s: begin
				if (cs_rise) begin
					next_state = scr_latch_s;
				end
			end
			scr_latch_s: begin
				next_state = scr_idle_s;
			end
			default: begin
				next_state = scr_idle_s;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= scr_idle_s;
		end else begin
			state <= next_state;
		end
	end

	// only the newest 20 bits survive, so long frames keep the tail
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shift_in <= scr_reg_reset;
		end else if (frame_active && sck_rise) begin
			shift_in <= {shift_in[18:0], sdi_sync[1]};
		end
	end

	// idle-high clock opens a frame with a fall; that one keeps the msb
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rise_seen <= 1'b0;
		end else if (!frame_active) begin
			rise_seen <= 1'b0;
		end else if (sck_rise) begin
			rise_seen <= 1'b1;
		end
	end

	// response word, msb first
	always_comb begin
		next_response = scr_reg_reset;
		case (response_select)
			scr_rd_position: begin
				next_response[19:10] = microstep_position;
			end
			scr_rd_load: begin
				next_response[19:10] = load_measurement;
			end
			scr_rd_load_scale: begin
				next_response[19:15] = load_measurement[9:5];
				next_response[14:10] = actual_current_scale;
			end
			default: begin
				next_response[19:10] = microstep_position;
			end
		endcase
		next_response[7:0] = {standstill, open_load_b, open_load_a,
			ground_short_b, ground_short_a, overtemp_prewarning,
			overtemp_shutdown, stall_flag};
	end

	// output changes after falling clock; past 20 bits it forwards input
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shift_out <= scr_reg_reset;
		end else if (cs_fall) begin
			shift_out <= next_response;
		end else if (frame_active && sck_fall && rise_seen) begin
			shift_out <= {shift_out[18:0], shift_in[0]};
		end
	end

	// after 20 falls the msb is the bit taken 20 rising edges earlier
	assign link_sdo = shift_out[19];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			latched <= scr_reg_reset;
		end else if (state == scr_shift_s && cs_rise) begin
			latched <= shift_in;
		end
	end
	assign cmd = latched;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			command_strobe <= 1'b0;
		end else begin
			command_strobe <= (state == scr_latch_s);
		end
	end

	// one target per command; the codes cannot overlap
	assign wr_driver_control = (state == scr_latch_s) &&
		(cmd[19:18] == scr_sel_drvctl);
	assign wr_chopper_config = (state == scr_latch_s) &&
		(cmd[19:17] == scr_sel_chop);
	assign wr_adaptive_current_config = (state == scr_latch_s) &&
		(cmd[19:17] == scr_sel_adapt);
	assign wr_load_sense_config = (state == scr_latch_s) &&
		(cmd[19:17] == scr_sel_sense);
	assign wr_driver_config = (state == scr_latch_s) &&
		(cmd[19:17] == scr_sel_drvcfg);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			driver_control <= scr_reg_reset;
		end else if (wr_driver_control) begin
			driver_control <= cmd;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			chopper_config <= scr_reg_reset;
		end else if (wr_chopper_config) begin
			chopper_config <= cmd;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			adaptive_current_config <= scr_reg_reset;
		end else if (wr_adaptive_current_config) begin
			adaptive_current_config <= cmd;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			load_sense_config <= scr_reg_reset;
		end else if (wr_load_sense_config) begin
			load_sense_config <= cmd;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			driver_config <= scr_reg_reset;
		end else if (wr_driver_config) begin
			driver_config <= cmd;
		end
	end

	// layout read from the held disable bit; a new value acts the cycle after its write
	assign step_direction_disable = driver_config[scr_pos_step_direction_disable];
	// fields of the layout not in use read zero
	always_comb begin
		coil_a_polarity = 1'b0;
		coil_a_magnitude = 8'h00;
		coil_b_polarity = 1'b0;
		coil_b_magnitude = 8'h00;
		step_interpolation = 1'b0;
		double_edge_step = 1'b0;
		microstep_resolution = 4'h0;
		if (step_direction_disable) begin
			coil_a_polarity = driver_control[scr_pos_pha];
			coil_a_magnitude = driver_control[scr_pos_ca +: 8];
			coil_b_polarity = driver_control[scr_pos_phb];
			coil_b_magnitude = driver_control[scr_pos_cb +: 8];
		end else begin
			step_interpolation = driver_control[scr_pos_step_interpolation];
			double_edge_step = driver_control[scr_pos_double_edge_step];
			microstep_resolution = driver_control[scr_pos_microstep_resolution +: 4];
		end
	end

	assign blank_time = chopper_config[16:15];
	assign chopper_mode_select = chopper_config[14];
	assign random_off_time = chopper_config[13];
	assign hysteresis_decrement = chopper_config[12:11];
	assign hysteresis_end = chopper_config[10:7];
	assign hysteresis_start = chopper_config[6:4];
	assign off_time = chopper_config[3:0];

	assign minimum_current_select = adaptive_current_config[15];
	assign decrement_speed = adaptive_current_config[14:13];
	assign upper_threshold = adaptive_current_config[11:8];
	assign increment_step = adaptive_current_config[6:5];
	assign lower_threshold = adaptive_current_config[3:0];

	assign measurement_filter = load_sense_config[16];
	assign load_threshold = load_sense_config[14:8];
	assign current_scale = load_sense_config[4:0];

	assign test_mode = driver_config[16];
	assign high_side_slope = driver_config[15:14];
	assign low_side_slope = driver_config[13:12];
	assign short_detect_disable = driver_config[10];
	assign short_detect_timer = driver_config[9:8];
	assign sense_voltage = driver_config[6];
	assign response_select = driver_config[scr_pos_response_select +: 2];
	// base part leaves these options dead
	assign overtemp_sensitivity = enhanced_variant &
		driver_config[scr_pos_overtemp_sensitivity];
	assign short_sensitivity = enhanced_variant &
		driver_config[scr_pos_short_sensitivity];
	assign supply_short_enable = enhanced_variant &
		driver_config[scr_pos_s2vs];
endmodule

/* File: verification/scr_props.sv */
// concurrent checks on the serial command register bank
// assumes binding onto scr_top; names match its ports
module scr_props (
	// system
	input wire logic clock,
	input wire logic arst_n,
	// link and variant
	input wire logic link_cs_n,
	input wire logic enhanced_variant,
	// raw registers
	input wire logic [19:0] driver_control,
	input wire logic [19:0] chopper_config,
	input wire logic [19:0] adaptive_current_config,
	input wire logic [19:0] driver_config,
	// decoded fields
	input wire logic step_direction_disable,
	input wire logic coil_a_polarity,
	input wire logic [7:0] coil_a_magnitude,
	input wire logic [3:0] microstep_resolution,
	input wire logic overtemp_sensitivity,
	input wire logic command_strobe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	chk_strobe_pulse: assert property (command_strobe |=> !command_strobe)
		else $error("command strobe wider than one cycle");
	chk_one_target: assert property ($onehot0({$changed(driver_control),
		$changed(chopper_config), $changed(adaptive_current_config),
		$changed(driver_config)})) else $error("two registers written at once");
	chk_write_strobe: assert property ($changed({driver_control,
		chopper_config, driver_config}) |-> command_strobe)
		else $error("register written without strobe");
	chk_chop_addr: assert property ($changed(chopper_config) |->
		chopper_config[19:17] == 3'h4) else $error("chopper address wrong");
	chk_adapt_addr: assert property ($changed(adaptive_current_config) |->
		adaptive_current_config[19:17] == 3'h5) else $error("adaptive address");
	chk_cfg_addr: assert property ($changed(driver_config) |->
		driver_config[19:17] == 3'h7) else $error("driver config address");
	chk_step_direction_disable_copy: assert property (step_direction_disable ==
		driver_config[7]) else $error("disable bit not from bit 7");
	chk_direct_map: assert property (step_direction_disable |->
		{coil_a_polarity, coil_a_magnitude} == driver_control[17:9])
		else $error("coil a fields wrong");
	chk_step_map: assert property (!step_direction_disable |->
		microstep_resolution == driver_control[3:0]) else $error("resolution");
	chk_base_ignore: assert property (!enhanced_variant |->
		!overtemp_sensitivity) else $error("base variant honours bit 3");
	chk_frame_quiet: assert property (!link_cs_n |->
		$stable(driver_config)) else $error("write inside a frame");
	cover property (command_strobe && step_direction_disable);
	cover property ($rose(link_cs_n));
	cover property (enhanced_variant && overtemp_sensitivity);
endmodule

bind scr_top scr_props u_props (.*);

/* File: verification/scr_host.sv */
// host-side serial master model, mode 3, link clock idle high
// assumes the device oversamples the link with a 50 MHz clock
module scr_host (
	// link pins
	output logic link_sck,
	output logic link_cs_n,
	output logic link_sdi,
	input wire logic link_sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_sck = 1'b1;
		link_cs_n = 1'b1;
		link_sdi = 1'b0;
	end
	// n bits of w go out msb first; r gathers sdo at each rising edge
	task automatic xfer(input int n, input logic [39:0] w,
		output logic [39:0] r);
		r = '0;
		link_cs_n = 1'b0;
		#160;
		for (int i = n - 1; i >= 0; i--) begin
			link_sck = 1'b0;
			link_sdi = w[i];
			#80;
			link_sck = 1'b1;
			r = {r[38:0], link_sdo};
			#80;
		end
		#80;
		link_cs_n = 1'b1;
		// a released line must not keep showing the last bit
		link_sdi = ~link_sdi;
		#240;
	endtask
endmodule

/* File: verification/scr_top_tb.sv */
// self-checking bench for the serial command register bank
// assumes scr_host as the link master and the bound checker
module scr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] chop_w = 20'h955a7;
	localparam logic [19:0] adapt_w = 20'hac965;
	localparam logic [19:0] sense_w = 20'hd4513;
	localparam logic [19:0] cfg_w = 20'hf5600;
	logic clock, arst_n, link_sck, link_cs_n, link_sdi, link_sdo;
	logic enhanced_variant, command_strobe;
	logic [9:0] microstep_position, load_measurement;
	logic [4:0] actual_current_scale, current_scale;
	logic standstill, open_load_b, open_load_a, ground_short_b;
	logic ground_short_a, overtemp_prewarning, overtemp_shutdown, stall_flag;
	logic [19:0] driver_control, chopper_config, adaptive_current_config;
	logic [19:0] load_sense_config, driver_config;
	logic step_direction_disable, coil_a_polarity, coil_b_polarity;
	logic [7:0] coil_a_magnitude, coil_b_magnitude;
	logic step_interpolation, double_edge_step, chopper_mode_select;
	logic random_off_time, minimum_current_select, measurement_filter;
	logic test_mode, short_detect_disable, sense_voltage;
	logic overtemp_sensitivity, short_sensitivity, supply_short_enable;
	logic [3:0] microstep_resolution, hysteresis_end, off_time;
	logic [3:0] upper_threshold, lower_threshold;
	logic [2:0] hysteresis_start;
	logic [6:0] load_threshold;
	logic [1:0] blank_time, hysteresis_decrement, decrement_speed;
	logic [1:0] increment_step, high_side_slope, low_side_slope;
	logic [1:0] short_detect_timer, response_select;
	logic [39:0] r;
	int err_count = 0;
	int tests_run = 0;
	scr_top uut (.*);
	scr_host host (.*);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input string nm, input logic [19:0] e,
		input logic [19:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [39:0] dcfg(logic sd, logic [1:0] rs,
		logic [3:0] lo);
		return {20'h0, 4'he, 8'h0, sd, 1'b0, rs, lo};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_regs();
		host.xfer(20, {20'h0, chop_w}, r);
		chk("chop", chop_w, chopper_config);
		chk("chop_f", {3'h0, chop_w[16:0]}, {blank_time, chopper_mode_select,
			random_off_time, hysteresis_decrement, hysteresis_end,
			hysteresis_start, off_time});
		host.xfer(20, {20'h0, adapt_w}, r);
		chk("adapt_f", {adapt_w[15:13], adapt_w[11:8], adapt_w[6:5],
			adapt_w[3:0]}, {minimum_current_select, decrement_speed,
			upper_threshold, increment_step, lower_threshold});
		host.xfer(20, {20'h0, sense_w}, r);
		chk("sense_f", {sense_w[16], sense_w[14:8], sense_w[4:0]},
			{measurement_filter, load_threshold, current_scale});
		host.xfer(20, {20'h0, cfg_w}, r);
		chk("cfg_f", {cfg_w[16:12], cfg_w[10:4]}, {test_mode,
			high_side_slope, low_side_slope, short_detect_disable,
			short_detect_timer, step_direction_disable, sense_voltage,
			response_select});
		chk("ctl_kept", 20'h0, driver_control);
		chk("chop_kept", chop_w, chopper_config);
		$display("t_regs done");
	endtask
	task automatic t_modes();
		host.xfer(20, dcfg(1'b1, 2'h0, 4'h0), r);
		host.xfer(20, {22'h0, 1'b1, 8'hf8, 1'b0, 8'h11}, r);
		chk("direct", {2'h0, 18'h3f011}, {coil_a_polarity, coil_a_magnitude,
			coil_b_polarity, coil_b_magnitude});
		host.xfer(20, dcfg(1'b0, 2'h0, 4'h0), r);
		host.xfer(20, {30'h0, 1'b1, 1'b0, 4'h0, 4'h8}, r);
		chk("stepdir", 20'h28, {step_interpolation, double_edge_step,
			microstep_resolution});
		$display("t_modes done");
	endtask
	task automatic t_resp();
		for (int rs = 0; rs < 3; rs++) begin
			host.xfer(20, dcfg(1'b0, 2'(rs), 4'h0), r);
			host.xfer(20, dcfg(1'b0, 2'(rs), 4'h0), r);
			case (rs)
				0: chk("resp0", {microstep_position, 8'ha5},
					{r[19:10], r[7:0]});
				1: chk("resp1", {10'h0, load_measurement}, r[19:10]);
				default: chk("resp2", {10'h0, load_measurement[9:5],
					actual_current_scale}, r[19:10]);
			endcase
		end
		$display("t_resp done");
	endtask
	task automatic t_chain();
		host.xfer(40, {20'h5a3c1, 20'h8f0e2}, r);
		chk("forward", 20'h5a3c1, r[19:0]);
		chk("last20", 20'h8f0e2, chopper_config);
		$display("t_chain done");
	endtask
	task automatic t_variant();
		host.xfer(20, dcfg(1'b0, 2'h0, 4'hd), r);
		chk("base", 20'h0, {overtemp_sensitivity, short_sensitivity,
			supply_short_enable});
		enhanced_variant = 1'b1;
		tick(2);
		chk("enh", 20'h7, {overtemp_sensitivity, short_sensitivity,
			supply_short_enable});
		$display("t_variant done");
	endtask
	initial begin
		arst_n = 1'b0;
		enhanced_variant = 1'b0;
		microstep_position = 10'h2b6;
		load_measurement = 10'h1c9;
		actual_current_scale = 5'h16;
		{standstill, open_load_b, open_load_a, ground_short_b, ground_short_a,
			overtemp_prewarning, overtemp_shutdown, stall_flag} = 8'ha5;
		tick(10);
		arst_n = 1'b1;
		tick(2);
		t_regs();
		t_modes();
		t_resp();
		t_chain();
		t_variant();
		report_and_stop();
	end
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
endmodule
